// File: embs_bus_ctrl.sv
// embs_bus_ctrl: sequencer for address latch, program and data strobes and bus ports
//
// Overview of operation
// - Reset needs pin high two machine cycles
// - Machine cycle six clocks, optionally twelve
// - Latch strobe marks low address on port
// - Latch strobe pulses twice per machine cycle
// - Data access drops one latch strobe pulse
// - Inhibit bit suppresses latch strobe normally
// - Latch strobe still emitted during data moves
// - External fetch: program strobe twice per cycle
// - Data access skips two program strobes
// - Program strobe idle for internal fetches
// - Fetch select low means external code
// - Fetch select caught at reset release
// - Low port multiplexes address and data
// - General low port floats written ones
// - Bus ports drive ones strongly
// - High port emits address for 16-bit access
// - High port shows latch for 8-bit access
// - Active-low read and write data strobes
module embs_bus_ctrl (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                rstPin,                // device reset pin, high
  input  wire logic                clkMode12,             // slow machine cycle option
  input  wire logic                aleInhibit,            // auxiliary control bit 0
  input  wire logic                externalFetchSelect_n, // low = external code
  input  wire logic [15:0]         codeAddr,              // next program address
  input  wire logic                dataReqValid,          // data access wanted
  input  wire embs_pkg::embs_dreq_t dataReq,              // data access details
  input  wire logic [7:0]          p0Latch,               // low port latch as general port
  input  wire logic [7:0]          p2Latch,               // high port latch
  input  wire logic [7:0]          p0In,                  // low port pin levels
  output logic                     dataAck_q,             // data request taken
  output logic                     dataDone_q,            // data access finished
  output logic [7:0]               readData_q,            // data read result
  output logic                     codeValid_q,           // code byte fetched
  output logic [7:0]               codeByte_q,            // fetched code byte
  output logic                     extFetch_q,            // latched fetch mode
  output logic                     coreRst_q,             // qualified core reset
  output embs_pkg::embs_strobe_t   strobe_q,              // control strobes
  output logic [7:0]               p0Out_q,               // low port output value
  output logic [7:0]               p0Oe_q,                // low port drive enables
  output logic [7:0]               p2Out_q                // high port output value
);

  // ---------------------------------------------------------------
  // reset qualification
  // ---------------------------------------------------------------
  logic rstAll;      // system or qualified pin reset
  logic cfg12_q;     // slow mode, fixed while running

  embs_reset_filter u_rst_filter (
    .clk       (clk),
    .rst_n     (rst_n),
    .rstPin    (rstPin),
    .mode12    (clkMode12),
    .coreRst_q (coreRst_q)
  );

  assign rstAll = !rst_n || coreRst_q;

  // ---------------------------------------------------------------
  // configuration captured during reset
  // ---------------------------------------------------------------
  // the fetch select pin is sampled every clock in reset, so the
  // value held at release is kept; later pin changes are ignored
  always_ff @(posedge clk) begin
    if (rstAll) begin
      extFetch_q <= !externalFetchSelect_n;
      cfg12_q    <= clkMode12;               // option treated as one-time
    end
  end

  // ---------------------------------------------------------------
  // state tick: one slot per clock, or per two in slow mode
  // ---------------------------------------------------------------
  logic pre_q;   // divide-by-two phase for slow mode
  logic tick;    // slot advance this clock

  always_ff @(posedge clk) begin
    if (rstAll) begin
      pre_q <= 1'b0;
    end else begin
      pre_q <= cfg12_q ? !pre_q : 1'b0;
    end
  end

  // 3 slots x 2 halves = 6 clocks, or 12 with the divider
  assign tick = !cfg12_q || pre_q;

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  embs_pkg::embs_slot_t slot_q, slotD;   // slot within the half
  logic                 half_q, halfD;   // second half of machine cycle
  logic                 dataCyc_q, dataCycD;  // this machine cycle is data
  logic                 newCyc;          // machine cycle boundary
  logic                 take;            // request accepted now
  embs_pkg::embs_dreq_t req_q, reqD;     // request in progress
  logic                 inhibit_q;       // latch inhibit seen with the pins

  // next slot, half and cycle kind
  always_comb begin
    slotD    = slot_q;
    halfD    = half_q;
    newCyc   = 1'b0;
    if (tick) begin
      case (slot_q)
        embs_pkg::SLOT_ADDR:   slotD = embs_pkg::SLOT_HOLD;
        embs_pkg::SLOT_HOLD:   slotD = embs_pkg::SLOT_STROBE;
        embs_pkg::SLOT_STROBE: begin
          slotD  = embs_pkg::SLOT_ADDR;
          halfD  = !half_q;
          newCyc = half_q;              // wrapped past the second half
        end
        default:               slotD = embs_pkg::SLOT_ADDR;
      endcase
    end
    take     = newCyc && dataReqValid;
    dataCycD = newCyc ? dataReqValid : dataCyc_q;
    reqD     = take ? dataReq : req_q;
  end

  // state registers; a request is only taken on a cycle boundary
  always_ff @(posedge clk) begin
    if (rstAll) begin
      slot_q    <= embs_pkg::SLOT_ADDR;
      half_q    <= 1'b0;
      dataCyc_q <= 1'b0;
      req_q     <= '0;
      dataAck_q <= 1'b0;
    end else begin
      slot_q    <= slotD;
      half_q    <= halfD;
      dataCyc_q <= dataCycD;
      req_q     <= reqD;
      dataAck_q <= take;
    end
  end

  // ---------------------------------------------------------------
  // strobe next values
  // ---------------------------------------------------------------
  logic         busHalfD;   // low port carries an address this half
  logic         fetchHalfD; // this half is an external code fetch
  embs_pkg::embs_strobe_t strobeD;

  always_comb begin
    fetchHalfD = extFetch_q && !dataCycD;
    busHalfD   = dataCycD ? !halfD : extFetch_q;
    strobeD    = embs_pkg::STROBE_IDLE;
    // first half of a data cycle keeps its pulse, second drops it
    strobeD.ale = (slotD == embs_pkg::SLOT_ADDR)
                  && !(dataCycD && halfD)
                  && (!aleInhibit || dataCycD);
    // program strobe only on external fetch halves
    strobeD.progRead_n = !(fetchHalfD && slotD == embs_pkg::SLOT_STROBE);
    // data strobes cover the whole second half of a data cycle
    strobeD.dataRead_n  = !(dataCycD && halfD && !reqD.write);
    strobeD.dataWrite_n = !(dataCycD && halfD && reqD.write);
  end

  always_ff @(posedge clk) begin
    if (rstAll) begin
      strobe_q  <= embs_pkg::STROBE_IDLE;
      inhibit_q <= 1'b0;
    end else begin
      strobe_q  <= strobeD;
      inhibit_q <= aleInhibit;
    end
  end

  // ---------------------------------------------------------------
  // low port: address, data or general port
  // ---------------------------------------------------------------
  logic [7:0] p0OutD;  // next low port value
  logic [7:0] p0OeD;   // next low port enables

  // address stays through the hold slot so it is stable when the
  // latch strobe falls; write data waits for the second half
  always_comb begin
    if (busHalfD && slotD != embs_pkg::SLOT_STROBE) begin
      p0OutD = dataCycD ? reqD.addr[7:0] : codeAddr[7:0];
      p0OeD  = 8'hff;
    end else if (dataCycD && halfD && reqD.write) begin
      p0OutD = reqD.wdata;
      p0OeD  = 8'hff;
    end else if (busHalfD || (dataCycD && halfD)) begin
      p0OutD = embs_pkg::BYTE_ZERO;                         // released for read data
      p0OeD  = embs_pkg::BYTE_ZERO;
    end else begin
      // open drain: ones float, zeros pull low
      p0OutD = embs_pkg::BYTE_ZERO;
      p0OeD  = ~p0Latch;
    end
  end

  always_ff @(posedge clk) begin
    if (rstAll) begin
      p0Out_q <= embs_pkg::BYTE_ZERO;
      p0Oe_q  <= embs_pkg::BYTE_ZERO;
    end else begin
      p0Out_q <= p0OutD;
      p0Oe_q  <= p0OeD;
    end
  end

  // ---------------------------------------------------------------
  // high port: address high byte or own latch
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rstAll) begin
      p2Out_q <= embs_pkg::PORT_RST_VAL;
    end else if (fetchHalfD || (dataCycD && reqD.useDptr)) begin
      p2Out_q <= dataCycD ? reqD.addr[15:8] : codeAddr[15:8];
    end else begin
      p2Out_q <= p2Latch;
    end
  end

  // ---------------------------------------------------------------
  // capture of code and read data at the end of the strobe slot
  // ---------------------------------------------------------------
  logic endStrobe;  // last clock of a strobe slot

  assign endStrobe = tick && (slot_q == embs_pkg::SLOT_STROBE);

  // a code byte per fetch half
  always_ff @(posedge clk) begin
    if (rstAll) begin
      codeByte_q  <= embs_pkg::BYTE_ZERO;
      codeValid_q <= 1'b0;
    end else begin
      codeValid_q <= endStrobe && extFetch_q && !dataCyc_q;
      if (endStrobe && extFetch_q && !dataCyc_q) begin
        codeByte_q <= p0In;
      end
    end
  end

  // data completes at the end of the second half
  always_ff @(posedge clk) begin
    if (rstAll) begin
      readData_q <= embs_pkg::BYTE_ZERO;
      dataDone_q <= 1'b0;
    end else begin
      dataDone_q <= endStrobe && dataCyc_q && half_q;
      if (endStrobe && dataCyc_q && half_q && !req_q.write) begin
        readData_q <= p0In;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rstAll);

  a_program_read_strobe_internal_idle: assert property (!extFetch_q |-> strobe_q.progRead_n)
    else $error("program strobe active during internal fetch");

  a_program_read_strobe_data_skip: assert property (dataCyc_q |-> strobe_q.progRead_n)
    else $error("program strobe active in a data cycle");

  a_ale_data_skip: assert property (dataCyc_q && half_q |-> !strobe_q.ale)
    else $error("latch strobe present in data second half");

  a_ale_inhibit_gate: assert property (strobe_q.ale |-> !inhibit_q || dataCyc_q)
    else $error("latch strobe not suppressed by inhibit bit");

  a_ale_pulse_width: assert property (
      $rose(strobe_q.ale) && !cfg12_q |=> !strobe_q.ale ##1 !strobe_q.ale ##1
      (strobe_q.ale || dataCyc_q || inhibit_q))
    else $error("latch strobe not repeating every three clocks");

  // internal fetch keeps the latch pulses but the low port stays a general port
  a_ale_addr_stable: assert property (
      $fell(strobe_q.ale) && (extFetch_q || dataCyc_q) |->
      (p0Oe_q == 8'hff) && $stable(p0Out_q))
    else $error("address not stable when latch strobe fell");

  a_strobe_exclusive: assert property (!(!strobe_q.dataRead_n && !strobe_q.dataWrite_n))
    else $error("read and write strobes both active");

  a_write_data_drive: assert property (
      !strobe_q.dataWrite_n |-> (p0Oe_q == 8'hff) && (p0Out_q == req_q.wdata))
    else $error("write data not driven during write strobe");

  a_p2_indirect_latch: assert property (
      dataCyc_q && !req_q.useDptr && $past(dataCyc_q) |-> p2Out_q == $past(p2Latch))
    else $error("high port not showing its latch in 8-bit access");

  a_fetch_sel_hold: assert property (!$past(rstAll) |-> $stable(extFetch_q))
    else $error("fetch mode changed after reset release");

  a_program_read_strobe_twice: assert property (
      extFetch_q && !dataCyc_q && slot_q == embs_pkg::SLOT_STROBE |-> !strobe_q.progRead_n)
    else $error("program strobe missing in fetch strobe slot");

endmodule : embs_bus_ctrl

// File: embs_mem_model.sv
// embs_mem_model: external code and data memory behind an address latch
module embs_mem_model (
  input  wire logic                   clk,
  input  wire embs_pkg::embs_strobe_t strobe,
  input  wire logic [7:0]             p0Out,
  input  wire logic [7:0]             p0Oe,
  input  wire logic [7:0]             p2Out,
  output logic [7:0]                  p0In
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] addrLo_q;            // captured low address
  logic [7:0] lastDrv_q = 8'h00;   // last byte offered, seeds the idle pattern
  logic [7:0] drive;               // byte the memory puts on the low port
  logic [7:0] mem [256];           // data memory, indexed by low address only

  // latch is transparent while the strobe is high; last capture is the address
  always_ff @(posedge clk) begin
    if (strobe.ale) addrLo_q <= p0In;
  end

  // write strobe low: port carries the write byte
  always_ff @(posedge clk) begin
    if (!strobe.dataWrite_n) mem[addrLo_q] <= p0In;
  end

  // answer the read strobes; a released bus toggles so stale data never looks valid
  always_comb begin
    if (!strobe.progRead_n) begin
      drive = addrLo_q ^ p2Out ^ 8'ha5;
    end else if (!strobe.dataRead_n) begin
      drive = mem[addrLo_q];
    end else begin
      drive = ~lastDrv_q;
    end
  end

  always_ff @(posedge clk) begin
    lastDrv_q <= drive;
  end

  // wire level: a driving bit wins over the memory
  assign p0In = (p0Oe & p0Out) | (~p0Oe & drive);
endmodule : embs_mem_model

// File: embs_pkg.sv
// embs_pkg: shared constants and carrier types for the external memory bus strobes
package embs_pkg;

  // ---------------------------------------------------------------
  // machine cycle timing
  // ---------------------------------------------------------------
  localparam int unsigned CLKS_PER_MC_FAST = 6;   // default machine cycle, oscillator clocks
  localparam int unsigned CLKS_PER_MC_SLOW = 12;  // optional slow machine cycle
  localparam int unsigned RST_HOLD_MC      = 2;   // machine cycles the reset pin must stay high
  localparam int unsigned RST_CNT_W        = 5;   // wide enough for 2 x 12 clocks

  // ---------------------------------------------------------------
  // reset values of the pins
  // ---------------------------------------------------------------
  localparam logic [7:0] PORT_RST_VAL = 8'hff;    // port latches come up all ones
  localparam logic [7:0] BYTE_ZERO    = 8'h00;    // cleared byte

  // ---------------------------------------------------------------
  // slot within one half machine cycle, one bit changes per step except the wrap to SLOT_ADDR
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SLOT_ADDR   = 2'b00,  // latch strobe high, address on the low port
    SLOT_HOLD   = 2'b01,  // latch strobe low, address still held
    SLOT_STROBE = 2'b11   // read strobe low, port handed to data
  } embs_slot_t;

  // ---------------------------------------------------------------
  // external data request from the core
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        write;    // 1 = write, 0 = read
    logic        useDptr;  // 16-bit data_pointer_pair address, else register_indirect_move
    logic [15:0] addr;     // data memory address
    logic [7:0]  wdata;    // write data
  } embs_dreq_t;

  // ---------------------------------------------------------------
  // control strobes driven to the pins
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ale;             // address latch strobe, active high
    logic progRead_n;      // program_read_strobe, active low
    logic dataRead_n;      // data read strobe, active low
    logic dataWrite_n;     // data write strobe, active low
  } embs_strobe_t;

  localparam embs_strobe_t STROBE_IDLE = '{ale: 1'b0, progRead_n: 1'b1,
                                           dataRead_n: 1'b1, dataWrite_n: 1'b1};

endpackage : embs_pkg

// File: embs_reset_filter.sv
// embs_reset_filter: qualifies the reset pin over two machine cycles
module embs_reset_filter (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic rstPin,     // device reset pin, active high
  input  wire logic mode12,     // slow machine cycle selected
  output logic      coreRst_q   // qualified core reset, active high
);

  // ---------------------------------------------------------------
  // hold limits in oscillator clocks
  // ---------------------------------------------------------------
  localparam logic [embs_pkg::RST_CNT_W-1:0] LIM_FAST =
    embs_pkg::RST_CNT_W'(embs_pkg::RST_HOLD_MC * embs_pkg::CLKS_PER_MC_FAST);
  localparam logic [embs_pkg::RST_CNT_W-1:0] LIM_SLOW =
    embs_pkg::RST_CNT_W'(embs_pkg::RST_HOLD_MC * embs_pkg::CLKS_PER_MC_SLOW);

  logic [embs_pkg::RST_CNT_W-1:0] cnt_q;  // consecutive high clocks seen
  logic [embs_pkg::RST_CNT_W-1:0] limit;  // clocks needed in current mode

  assign limit = mode12 ? LIM_SLOW : LIM_FAST;

  // count while the pin stays high; a short glitch restarts the count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (!rstPin) begin
      cnt_q <= '0;
    end else if (cnt_q != limit) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // reset holds only after the full hold time, drops with the pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coreRst_q <= 1'b0;
    end else begin
      coreRst_q <= rstPin && (cnt_q == limit);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_rst_hold_time: assert property ($rose(coreRst_q) |-> $past(cnt_q) == limit)
    else $error("core reset rose before the pin was high two machine cycles");

endmodule : embs_reset_filter

// File: external_memory_bus_strobes_test.sv
// external_memory_bus_strobes_test: self-checking bench for the bus strobe sequencer
module external_memory_bus_strobes_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   rstPin = 1'b0;
  logic                   clkMode12 = 1'b0;
  logic                   aleInhibit = 1'b0;
  logic                   externalFetchSelect_n = 1'b0;
  logic [15:0]            codeAddr = 16'h12c3;
  logic                   dataReqValid = 1'b0;
  embs_pkg::embs_dreq_t   dataReq = '0;
  logic [7:0]             p0Latch = 8'hff;
  logic [7:0]             p2Latch = 8'h3c;
  logic [7:0]             p0In;
  logic                   dataAck_q, dataDone_q, codeValid_q, extFetch_q, coreRst_q;
  logic [7:0]             readData_q, codeByte_q, p0Out_q, p0Oe_q, p2Out_q;
  embs_pkg::embs_strobe_t strobe_q;
  int                     fail_count = 0;
  int                     cmp_count = 0;
  int                     nAle, nProg, nRd, nWr;  // events seen in a window

  always #2 clk = ~clk;

  embs_bus_ctrl dut_u (.clk(clk), .rst_n(rst_n), .rstPin(rstPin), .clkMode12(clkMode12),
    .aleInhibit(aleInhibit), .externalFetchSelect_n(externalFetchSelect_n),
    .codeAddr(codeAddr), .dataReqValid(dataReqValid), .dataReq(dataReq), .p0Latch(p0Latch),
    .p2Latch(p2Latch), .p0In(p0In), .dataAck_q(dataAck_q), .dataDone_q(dataDone_q),
    .readData_q(readData_q), .codeValid_q(codeValid_q), .codeByte_q(codeByte_q),
    .extFetch_q(extFetch_q), .coreRst_q(coreRst_q), .strobe_q(strobe_q),
    .p0Out_q(p0Out_q), .p0Oe_q(p0Oe_q), .p2Out_q(p2Out_q));

  embs_mem_model mem_u (.clk(clk), .strobe(strobe_q), .p0Out(p0Out_q), .p0Oe(p0Oe_q),
    .p2Out(p2Out_q), .p0In(p0In));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // a bound that runs out is a mismatch and ends the run
  task automatic timeout(input string what);
    fail_count++;
    $display("[ERR] %s expected event seen none", what);
    end_sim();
  endtask : timeout

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  // count latch and program strobe pulses, and data strobe low samples, over n settled samples, the current one first
  task automatic watch(input int n);
    logic pa, pp;
    pa = 1'b0;
    pp = 1'b1;
    {nAle, nProg, nRd, nWr} = '0;
    for (int i = 0; i < n; i++) begin
      if (i > 0) begin
        @(posedge clk);
        dataReqValid <= 1'b0;  // one access only: valid drops after the take
        #1;
      end
      nAle += int'(strobe_q.ale && !pa);
      nProg += int'(!strobe_q.progRead_n && pp);
      nRd += int'(!strobe_q.dataRead_n);
      nWr += int'(!strobe_q.dataWrite_n);
      pa = strobe_q.ale;
      pp = strobe_q.progRead_n;
    end
  endtask : watch

  // stop on the sample where the latch strobe has just risen
  task automatic syncAle;
    logic p;
    p = 1'b1;
    for (int k = 0; k < 40; k++) begin
      tick();
      if (strobe_q.ale === 1'b1 && p === 1'b0) return;
      p = strobe_q.ale;
    end
    timeout("ale rise");
  endtask : syncAle

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic doReset(input logic m12, input logic sel_n);
    @(posedge clk);
    rst_n <= 1'b0;
    clkMode12 <= m12;
    externalFetchSelect_n <= sel_n;
    repeat (3) @(posedge clk);
    #1;
    chk("strobes in reset", strobe_q, embs_pkg::STROBE_IDLE);
    chk("p2 in reset", p2Out_q, 8'hff);
    @(posedge clk);
    rst_n <= 1'b1;
    tick();
    chk("fetch mode", extFetch_q, !sel_n);
  endtask : doReset

  // reset pin held n edges; only two machine cycles of it reset the core
  task automatic pinReset(input int n, input logic exp);
    @(posedge clk);
    rstPin <= 1'b1;
    repeat (n) @(posedge clk);
    rstPin <= 1'b0;
    #1;
    chk("core reset", coreRst_q, exp);
    repeat (3) tick();
    chk("core reset off", coreRst_q, 1'b0);
  endtask : pinReset

  // code fetch: address on both ports, then the fetched byte
  task automatic fetchOne;
    int k;
    syncAle();
    chk("p0 addr", p0Out_q, codeAddr[7:0]);
    chk("p0 oe", p0Oe_q, 8'hff);
    chk("p2 addr", p2Out_q, codeAddr[15:8]);
    tick();
    chk("p0 addr after ale", {strobe_q.ale, p0Out_q}, {1'b0, codeAddr[7:0]});
    for (k = 0; k < 20 && codeValid_q !== 1'b1; k++) tick();
    if (k == 20) timeout("code valid");
    chk("code byte", codeByte_q, codeAddr[7:0] ^ codeAddr[15:8] ^ 8'ha5);
  endtask : fetchOne

  task automatic dataAcc(input logic wr, input logic dp, input logic [15:0] a,
                         input logic [7:0] wd, input logic [7:0] rdExp, input int progExp);
    int k;
    @(posedge clk);
    dataReq <= '{write: wr, useDptr: dp, addr: a, wdata: wd};
    dataReqValid <= 1'b1;
    #1;
    for (k = 0; k < 20 && dataAck_q !== 1'b1; k++) tick();
    if (k == 20) timeout("data ack");
    chk("data p0 addr", p0Out_q, a[7:0]);
    chk("data p2", p2Out_q, dp ? a[15:8] : p2Latch);
    watch(6);
    chk("data ale pulses", nAle, 1);
    chk("data prog strobes", nProg, progExp);
    chk("write strobe", nWr, wr ? 3 : 0);
    chk("read strobe", nRd, wr ? 0 : 3);
    tick();
    chk("done", dataDone_q, 1'b1);
    if (!wr) chk("read data", readData_q, rdExp);
  endtask : dataAcc

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    doReset(1'b0, 1'b0);
    pinReset(10, 1'b0);
    pinReset(14, 1'b1);
    fetchOne();
    syncAle();
    watch(12);
    chk("ale per 2 cycles", nAle, 4);
    chk("prog per 2 cycles", nProg, 4);
    @(posedge clk);
    externalFetchSelect_n <= 1'b1;  // late change must be ignored
    syncAle();
    watch(12);
    chk("prog after pin change", nProg, 4);
    chk("fetch mode kept", extFetch_q, 1'b1);
    dataAcc(1'b1, 1'b1, 16'h7e41, 8'h96, 8'h00, 0);
    dataAcc(1'b0, 1'b0, 16'h0041, 8'h00, 8'h96, 0);
    @(posedge clk);
    p0Latch <= 8'h5a;
    doReset(1'b0, 1'b1);
    tick();
    chk("general port oe", p0Oe_q, 8'ha5);
    chk("general port out", p0Out_q, 8'h00);
    syncAle();
    watch(12);
    chk("internal prog", nProg, 0);
    chk("internal ale", nAle, 4);
    @(posedge clk);
    aleInhibit <= 1'b1;
    repeat (6) tick();
    watch(12);
    chk("inhibited ale", nAle, 0);
    dataAcc(1'b0, 1'b0, 16'h0041, 8'h00, 8'h96, 0);
    @(posedge clk);
    aleInhibit <= 1'b0;
    doReset(1'b1, 1'b0);
    syncAle();
    watch(24);
    chk("slow ale", nAle, 4);
    chk("slow prog", nProg, 4);
    end_sim();
  end
endmodule : external_memory_bus_strobes_test
